// file: verilog/gpio_ab_consts.vh
// register offsets, reset values and widths for the shared port block
`ifndef GPIO_AB_CONSTS_VH
`define GPIO_AB_CONSTS_VH
`define PORT_A_DATA_IDX       4'h0
`define PORT_B_DATA_IDX       4'h1
`define PORT_C_DATA_IDX       4'h2
`define PORT_A_DIR_IDX        4'h4
`define PORT_B_DIR_IDX        4'h5
`define PORT_C_DIR_IDX        4'h6
`define PORT_A_PULLUP_IDX     4'hD
`define PORT_C_PULLUP_IDX     4'hE
`define KBI_ENABLE_IDX        4'h8
`define CONV_SELECT_IDX       4'h9
`define PERIPH_CLAIM_IDX      4'hA
`define ADDR_W                6
`define DIR_RESET             8'h00
`define PULLUP_RESET          8'h00
`define CTRL_RESET            8'h00
`define CONV_NONE             5'h1F
`define CLAIM_SERIAL_BIT      0
`define CLAIM_ASYNC_BIT       1
`define CLAIM_BUSCTL_BIT      2
`define CLAIM_TIMER_BIT       3
`endif

// file: verilog/gpio_port_slice.v
// one bidirectional port: latch, direction, pullup and pin mux
`timescale 1ns/1ps
`default_nettype none
module gpio_port_slice #(
    parameter W = 8
) (
    input  wire         clk_sys_i,
    input  wire         rst_i,
    input  wire         wr_data_i,
    input  wire         wr_dir_i,
    input  wire         wr_pull_i,
    input  wire [W-1:0] wdata_i,
    input  wire [W-1:0] pin_i,
    input  wire [W-1:0] claim_i,
    input  wire [W-1:0] claim_out_i,
    input  wire [W-1:0] claim_oe_i,
    input  wire [W-1:0] analog_i,
    output wire [W-1:0] latch_o,
    output wire [W-1:0] dir_o,
    output wire [W-1:0] pull_o,
    output wire [W-1:0] read_o,
    output wire [W-1:0] pin_o,
    output wire [W-1:0] pin_oe_n_o,
    output wire [W-1:0] pullup_on_o
);
    reg [W-1:0] latch_q;
    reg [W-1:0] dir_q;
    reg [W-1:0] pull_q;

    // latch has no reset: its contents survive a reset
    always @(posedge clk_sys_i)
    begin
        if (wr_data_i)
            latch_q <= wdata_i; // (R02) (R06)
    end

    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            dir_q  <= {W{1'b0}}; // (R04) (R09)
            pull_q <= {W{1'b0}};
        end
        else
        begin
            if (wr_dir_i)
                dir_q <= wdata_i;
            if (wr_pull_i)
                pull_q <= wdata_i;
        end
    end

    assign latch_o     = latch_q;
    assign dir_o       = dir_q;
    assign pull_o      = pull_q;
    // readback follows direction even when a peripheral owns the pin
    assign read_o      = (dir_q & latch_q) | (~dir_q & pin_i); // (R05) (R10)
    assign pin_o       = (claim_i & claim_out_i) | (~claim_i & latch_q); // (R14)
    // analog select overrides every digital driver on that pin
    assign pin_oe_n_o  = ~(~analog_i & ((claim_i & claim_oe_i) | (~claim_i & dir_q))); // (R03) (R08)
    assign pullup_on_o = pull_q & ~dir_q & ~claim_i & ~analog_i; // (R07) (R12)
endmodule // gpio_port_slice
`default_nettype wire

// file: verilog/gpio_ports.v
// shared general-purpose ports a, b and c behind an avalon-mm slave
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_ab_consts.vh"
// Notes on behaviour
// (R01) port a: eight pins, keyboard inputs when enabled
// (R02) data latches keep contents through reset
// (R03) direction 1 drives pin, 0 makes input
// (R04) reset clears port a directions
// (R05) port a read: latch if output, else pin
// (R06) data writes always update the latch; a write with avs_byteenable_i[0] low leaves it unchanged here
// (R07) port a pullup only while pin is input
// (R08) converter channel select forces port b analog input
// (R09) reset clears port b directions
// (R10) port b read: latch if output, else pin
// (R11) software loads latch before enabling output
// (R12) port c: seven pins with input pullups
// (R13) port b has no pullup, high-impedance input
// (R14) peripherals claim pins when their enables set; only the bus controller enable claims pins here (port c pins 0 and 1)
module gpio_ports (
    input  wire        clk_sys_i,
    input  wire        rst_i,
    input  wire [5:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [3:0]  avs_byteenable_i,
    input  wire [31:0] avs_writedata_i,
    output wire [31:0] avs_readdata_o,
    output wire        avs_waitrequest_o,
    input  wire [7:0]  port_a_pin_i,
    output wire [7:0]  port_a_pin_o,
    output wire [7:0]  port_a_pin_oe_n_o,
    output wire [7:0]  port_a_pullup_o,
    output wire [7:0]  keyboard_inputs_o,
    input  wire [7:0]  port_b_pin_i,
    output wire [7:0]  port_b_pin_o,
    output wire [7:0]  port_b_pin_oe_n_o,
    output wire [7:0]  analog_inputs_o,
    input  wire [6:0]  port_c_pin_i,
    output wire [6:0]  port_c_pin_o,
    output wire [6:0]  port_c_pin_oe_n_o,
    output wire [6:0]  port_c_pullup_o,
    input  wire [1:0]  bus_controller_tx_i,
    output wire [1:0]  bus_controller_rx_o,
    output wire        serial_peripheral_enable_o,
    output wire        async_serial_enable_o,
    output wire        bus_controller_pin_enable_o,
    output wire        timer_edge_level_select_o
);
    // ************************************************************
    // bus slave
    // ************************************************************
    // one-cycle wait: data are registered, answer at second edge
    reg         ack_q;
    reg  [31:0] rdata_q;
    reg  [7:0]  kbi_en_q;
    reg  [4:0]  conv_sel_q;
    reg  [7:0]  claim_q;
    wire        req   = (avs_read_i | avs_write_i) & ~ack_q;
    // writes commit only at the edge where waitrequest is seen low
    wire        wr_ok = avs_write_i & ack_q & avs_byteenable_i[0];
    wire [3:0]  idx   = avs_address_i[5:2];
    wire        wa_d  = wr_ok & (idx == `PORT_A_DATA_IDX);
    wire        wb_d  = wr_ok & (idx == `PORT_B_DATA_IDX);
    wire        wc_d  = wr_ok & (idx == `PORT_C_DATA_IDX);
    wire        wa_r  = wr_ok & (idx == `PORT_A_DIR_IDX);
    wire        wb_r  = wr_ok & (idx == `PORT_B_DIR_IDX);
    wire        wc_r  = wr_ok & (idx == `PORT_C_DIR_IDX);
    wire        wa_p  = wr_ok & (idx == `PORT_A_PULLUP_IDX);
    wire        wc_p  = wr_ok & (idx == `PORT_C_PULLUP_IDX);

    assign avs_waitrequest_o = req;
    assign avs_readdata_o    = rdata_q;

    // ************************************************************
    // peripheral sharing
    // ************************************************************
    wire [7:0] a_lat, a_dir, a_pul, a_rd;
    wire [7:0] b_lat, b_dir, b_pul, b_rd;
    wire [6:0] c_lat, c_dir, c_pul, c_rd;
    wire [7:0] analog_sel;
    wire [6:0] c_claim;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_conv
            assign analog_sel[g] = (conv_sel_q == g); // (R08)
        end
    endgenerate
    // only the low two port c pins are shared, so a 2-bit claim suffices
    assign c_claim = {5'h00, claim_q[`CLAIM_BUSCTL_BIT], claim_q[`CLAIM_BUSCTL_BIT]}; // (R14)

    assign keyboard_inputs_o          = kbi_en_q & port_a_pin_i; // (R01)
    assign analog_inputs_o            = analog_sel;
    assign bus_controller_rx_o        = port_c_pin_i[1:0] & {2{claim_q[`CLAIM_BUSCTL_BIT]}};
    assign serial_peripheral_enable_o = claim_q[`CLAIM_SERIAL_BIT];
    assign async_serial_enable_o      = claim_q[`CLAIM_ASYNC_BIT];
    assign bus_controller_pin_enable_o = claim_q[`CLAIM_BUSCTL_BIT];
    assign timer_edge_level_select_o  = claim_q[`CLAIM_TIMER_BIT];

    // ************************************************************
    // ports
    // ************************************************************
    gpio_port_slice #(.W(8)) u_port_a (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .wr_data_i   (wa_d),
        .wr_dir_i    (wa_r),
        .wr_pull_i   (wa_p),
        .wdata_i     (avs_writedata_i[7:0]),
        .pin_i       (port_a_pin_i),
        .claim_i     (8'h00),
        .claim_out_i (8'h00),
        .claim_oe_i  (8'h00),
        .analog_i    (8'h00),
        .latch_o     (a_lat),
        .dir_o       (a_dir),
        .pull_o      (a_pul),
        .read_o      (a_rd),
        .pin_o       (port_a_pin_o),
        .pin_oe_n_o  (port_a_pin_oe_n_o),
        .pullup_on_o (port_a_pullup_o)
    );

    // pullup write strobe tied off: port b has no pullup register
    gpio_port_slice #(.W(8)) u_port_b (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .wr_data_i   (wb_d),
        .wr_dir_i    (wb_r),
        .wr_pull_i   (1'b0), // (R13)
        .wdata_i     (avs_writedata_i[7:0]),
        .pin_i       (port_b_pin_i),
        .claim_i     (8'h00),
        .claim_out_i (8'h00),
        .claim_oe_i  (8'h00),
        .analog_i    (analog_sel),
        .latch_o     (b_lat),
        .dir_o       (b_dir),
        .pull_o      (b_pul),
        .read_o      (b_rd),
        .pin_o       (port_b_pin_o),
        .pin_oe_n_o  (port_b_pin_oe_n_o),
        .pullup_on_o ()
    );

    gpio_port_slice #(.W(7)) u_port_c (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .wr_data_i   (wc_d),
        .wr_dir_i    (wc_r),
        .wr_pull_i   (wc_p),
        .wdata_i     (avs_writedata_i[6:0]),
        .pin_i       (port_c_pin_i),
        .claim_i     (c_claim),
        .claim_out_i ({5'h00, bus_controller_tx_i}),
        .claim_oe_i  (7'h01),
        .analog_i    (7'h00),
        .latch_o     (c_lat),
        .dir_o       (c_dir),
        .pull_o      (c_pul),
        .read_o      (c_rd),
        .pin_o       (port_c_pin_o),
        .pin_oe_n_o  (port_c_pin_oe_n_o),
        .pullup_on_o (port_c_pullup_o) // (R12)
    );

    // ************************************************************
    // control registers and readback
    // ************************************************************
    reg [7:0] rd_d;
    always @*
    begin
        case (idx)
            `PORT_A_DATA_IDX:   rd_d = a_rd;
            `PORT_B_DATA_IDX:   rd_d = b_rd;
            `PORT_C_DATA_IDX:   rd_d = {1'b0, c_rd};
            `PORT_A_DIR_IDX:    rd_d = a_dir;
            `PORT_B_DIR_IDX:    rd_d = b_dir;
            `PORT_C_DIR_IDX:    rd_d = {1'b0, c_dir};
            `PORT_A_PULLUP_IDX: rd_d = a_pul;
            `PORT_C_PULLUP_IDX: rd_d = {1'b0, c_pul};
            `KBI_ENABLE_IDX:    rd_d = kbi_en_q;
            `CONV_SELECT_IDX:   rd_d = {3'h0, conv_sel_q};
            `PERIPH_CLAIM_IDX:  rd_d = {4'h0, claim_q[3:0]};
            default:            rd_d = 8'h00;
        endcase
    end

    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ack_q      <= 1'b0;
            rdata_q    <= 32'h00000000;
            kbi_en_q   <= `CTRL_RESET;
            conv_sel_q <= `CONV_NONE;
            claim_q    <= `CTRL_RESET;
        end
        else
        begin
            ack_q <= req;
            if (avs_read_i & ~ack_q)
                rdata_q <= {24'h000000, rd_d};
            if (wr_ok & (idx == `KBI_ENABLE_IDX))
                kbi_en_q <= avs_writedata_i[7:0]; // (R01)
            if (wr_ok & (idx == `CONV_SELECT_IDX))
                conv_sel_q <= avs_writedata_i[4:0];
            if (wr_ok & (idx == `PERIPH_CLAIM_IDX))
                claim_q <= {4'h0, avs_writedata_i[3:0]}; // (R14)
        end
    end

    // b_pul, b_lat, a_lat and c_lat feed no readback path or output
    wire unused_ok = &{1'b0, b_pul, b_lat, a_lat, c_lat};
endmodule // gpio_ports
`default_nettype wire

// file: verif/gpio_ports_asserts.sv
// concurrent checks on the port block bus and pins
`timescale 1ns/1ps
`default_nettype none
// *****
// checker
// *****
module gpio_ports_asserts (
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    input wire logic [5:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [7:0]  port_a_pin_i,
    input wire logic [7:0]  port_a_pin_o,
    input wire logic [7:0]  port_a_pin_oe_n_o,
    input wire logic [7:0]  port_a_pullup_o,
    input wire logic [7:0]  keyboard_inputs_o,
    input wire logic [7:0]  port_b_pin_oe_n_o,
    input wire logic [7:0]  analog_inputs_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_done;
        (avs_read_i || avs_write_i) && !avs_waitrequest_o;
    endsequence
    a_one_wait: assert property (s_req |=> s_done) else $error("wait state not one cycle");
    a_wait_first: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
        else $error("no wait in first cycle");
    a_dir_write: assert property (s_done ##0 (avs_write_i && avs_address_i == 6'h10 && avs_byteenable_i[0])
        |=> port_a_pin_oe_n_o == ~$past(avs_writedata_i[7:0])) else $error("direction not on driver");
    a_no_early: assert property (s_req ##0 (avs_write_i && avs_address_i == 6'h10 && avs_byteenable_i[0])
        |=> $stable(port_a_pin_oe_n_o)) else $error("write landed before wait ended");
    a_latch_write: assert property (s_done ##0 (avs_write_i && avs_address_i == 6'h00 && avs_byteenable_i[0])
        |=> port_a_pin_o == $past(avs_writedata_i[7:0])) else $error("latch not updated");
    a_read_mix: assert property (s_done ##0 (avs_read_i && avs_address_i == 6'h00)
        |-> avs_readdata_o[7:0] == (($past(port_a_pin_o) & ~$past(port_a_pin_oe_n_o))
        | ($past(port_a_pin_i) & $past(port_a_pin_oe_n_o)))) else $error("bad port read");
    a_pull_input: assert property ((port_a_pullup_o & ~port_a_pin_oe_n_o) == 8'h00)
        else $error("pullup on output");
    a_kbd_gate: assert property ((keyboard_inputs_o & ~port_a_pin_i) == 8'h00)
        else $error("keyboard input not from pin");
    a_analog_hiz: assert property ($onehot0(analog_inputs_o) && (analog_inputs_o & ~port_b_pin_oe_n_o) == 8'h00)
        else $error("analog pin driven");
    a_reset_in: assert property ($fell(rst_i) |-> port_a_pin_oe_n_o == 8'hFF && port_b_pin_oe_n_o == 8'hFF)
        else $error("pins not inputs after reset");
    a_read_hi: assert property (avs_readdata_o[31:8] == 24'h0) else $error("upper read bits set");
endmodule // gpio_ports_asserts
`default_nettype wire

// file: verif/pin_model.sv
// pad model: driver, external source, pullup or wandering float
`timescale 1ns/1ps
`default_nettype none
// *****
// pins
// *****
module pin_model #(parameter W = 8) (
    input wire logic         clk_sys_i,
    input wire logic [W-1:0] drv_i,
    input wire logic [W-1:0] oe_n_i,
    input wire logic [W-1:0] pull_i,
    input wire logic [W-1:0] ext_i,
    input wire logic [W-1:0] ext_en_i,
    output logic     [W-1:0] lvl_o
);
    logic t_q = 1'b0;
    always @(posedge clk_sys_i) t_q <= ~t_q;
    // a floating pin toggles so a stale level never passes for a match
    always_comb
        for (int k = 0; k < W; k++)
            lvl_o[k] = !oe_n_i[k] ? drv_i[k] : ext_en_i[k] ? ext_i[k] : pull_i[k] ? 1'b1 : t_q;
endmodule // pin_model
`default_nettype wire

// file: verif/shared_gpio_ports_a_b_test.sv
// self-checking bench for the shared port block
`timescale 1ns/1ps
`default_nettype none
// *****
// bench
// *****
module shared_gpio_ports_a_b_test;
    logic clk_sys_i = 0, rst_i = 1, avs_read_i = 0, avs_write_i = 0;
    logic [5:0] avs_address_i = 6'h00;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [31:0] avs_writedata_i = 32'h0, q;
    logic [7:0] ext = 8'h00, en = 8'h00;
    logic [1:0] bus_controller_tx_i = 2'h0;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o, serial_peripheral_enable_o, async_serial_enable_o;
    wire bus_controller_pin_enable_o, timer_edge_level_select_o;
    wire [7:0] port_a_pin_i, port_a_pin_o, port_a_pin_oe_n_o, port_a_pullup_o, keyboard_inputs_o;
    wire [7:0] port_b_pin_i, port_b_pin_o, port_b_pin_oe_n_o, analog_inputs_o;
    wire [6:0] port_c_pin_i, port_c_pin_o, port_c_pin_oe_n_o, port_c_pullup_o;
    wire [1:0] bus_controller_rx_o;
    int error_cnt = 0, n_checks = 0;
    typedef struct packed {logic [5:0] off; logic [7:0] dir, dat, pu, en, ext, exp;} row_t;
    row_t r;
    row_t rows [7] = '{'{6'h00, 8'h00, 8'h3C, 8'h00, 8'hFF, 8'hA5, 8'hA5},
        '{6'h00, 8'hF0, 8'h3C, 8'h00, 8'h0F, 8'h0A, 8'h3A}, '{6'h00, 8'h0F, 8'hC3, 8'hFF, 8'h00, 8'h00, 8'hF3},
        '{6'h04, 8'h00, 8'h11, 8'h00, 8'hFF, 8'h5A, 8'h5A}, '{6'h04, 8'hFF, 8'h96, 8'h00, 8'h00, 8'h00, 8'h96},
        '{6'h08, 8'h00, 8'h55, 8'hFF, 8'h00, 8'h00, 8'h7F}, '{6'h08, 8'h7F, 8'h2A, 8'h00, 8'h00, 8'h00, 8'h2A}};
    gpio_ports gpio_ports_i (.*);
    pin_model #(8) pin_model_i (.clk_sys_i, .drv_i(port_a_pin_o), .oe_n_i(port_a_pin_oe_n_o),
        .pull_i(port_a_pullup_o), .ext_i(ext), .ext_en_i(en), .lvl_o(port_a_pin_i));
    pin_model #(8) pin_model_b_i (.clk_sys_i, .drv_i(port_b_pin_o), .oe_n_i(port_b_pin_oe_n_o),
        .pull_i(8'h00), .ext_i(ext), .ext_en_i(en), .lvl_o(port_b_pin_i));
    pin_model #(7) pin_model_c_i (.clk_sys_i, .drv_i(port_c_pin_o), .oe_n_i(port_c_pin_oe_n_o),
        .pull_i(port_c_pullup_o), .ext_i(ext[6:0]), .ext_en_i(en[6:0]), .lvl_o(port_c_pin_i));
    task give_verdict;
        if (error_cnt == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [47:0] e, input logic [47:0] a);
        n_checks++;
        if (a !== e)
        begin
            $display("unexpected at %0t: exp %h got %h", $time, e, a);
            error_cnt++;
        end
    endtask
    // master holds the request until waitrequest is seen low
    task bus(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_address_i <= a;
        avs_writedata_i <= {24'h0, d};
        @(posedge clk_sys_i);
        while (avs_waitrequest_o !== 1'b0)
            @(posedge clk_sys_i);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        // a write lands at the accepting edge, so let one edge pass before outputs are looked at
        @(posedge clk_sys_i);
    endtask
    task rd(input logic [5:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(e, q);
    endtask
    initial forever #5 clk_sys_i = ~clk_sys_i;
    initial
    begin
        #20000;
        error_cnt++;
        give_verdict;
    end
    initial
    begin
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        chk({port_a_pin_oe_n_o, port_b_pin_oe_n_o, port_c_pin_oe_n_o, port_a_pullup_o, port_c_pullup_o,
            analog_inputs_o}, {8'hFF, 8'hFF, 7'h7F, 8'h00, 7'h00, 8'h00});
        foreach (rows[i])
        begin
            r = rows[i];
            ext <= r.ext;
            en <= r.en;
            bus(1'b1, r.off, r.dat);
            bus(1'b1, r.off + 6'h10, r.dir);
            bus(1'b1, 6'h34, r.pu);
            bus(1'b1, 6'h38, r.pu);
            rd(r.off, r.exp);
            rd(r.off + 6'h10, r.dir);
        end
        rd(6'h3C, 8'h00);
        avs_byteenable_i <= 4'h0;
        bus(1'b1, 6'h00, 8'h00);
        avs_byteenable_i <= 4'hF;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        chk({port_a_pin_o, port_a_pin_oe_n_o}, {8'hC3, 8'hFF});
        ext <= 8'h66;
        en <= 8'hFF;
        bus(1'b1, 6'h20, 8'h0F);
        chk(8'h06, keyboard_inputs_o);
        bus(1'b1, 6'h14, 8'hFF);
        bus(1'b1, 6'h24, 8'h03);
        chk({port_b_pin_oe_n_o, analog_inputs_o, port_b_pin_o}, {8'h08, 8'h08, 8'h96});
        bus_controller_tx_i <= 2'b01;
        ext <= 8'h02;
        bus(1'b1, 6'h28, 8'h0F);
        chk({serial_peripheral_enable_o, async_serial_enable_o, bus_controller_pin_enable_o,
            timer_edge_level_select_o, port_c_pin_oe_n_o[0], port_c_pin_o[0], bus_controller_rx_o},
            {4'hF, 1'b0, 1'b1, 2'b11});
        give_verdict;
    end
endmodule // shared_gpio_ports_a_b_test
bind gpio_ports gpio_ports_asserts gpio_ports_asserts_i (.*);
`default_nettype wire
